// ==== nco_out_pkg.sv ====
package nco_out_pkg;

  // phase and lookup widths
  localparam int PHASE_W = 32;
  localparam int ADDR_W = 20;
  localparam int ADDR_LSB = PHASE_W - ADDR_W;
  localparam int QUAD_W = 2;
  localparam int RESID_W = ADDR_W - QUAD_W;
  localparam int OUT_W = 16;

  // rotation pipeline
  localparam int ITER = 18;
  localparam int GUARD = 4;
  localparam int Z_W = 24;
  localparam int XY_W = 22;
  localparam logic signed [XY_W-1:0] X_INIT = 22'sh04DB9E;
  localparam logic signed [OUT_W:0] OUT_POS_MAX = 17'sh07FFF;
  localparam logic signed [OUT_W:0] OUT_NEG_MAX = -17'sh07FFF;
  localparam real TWO_PI = 6.283185307179586;

  // buffer
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = 2 * OUT_W;

  // phase test mode layout
  localparam int TEST_COS_LSB = 4;

  // register map, byte offsets
  localparam int AV_ADDR_W = 4;
  localparam logic [AV_ADDR_W-1:0] CFG_OFF = 4'h0;
  localparam logic [AV_ADDR_W-1:0] STATUS_OFF = 4'h4;
  localparam int CFG_TEST_BIT = 0;
  localparam logic CFG_TEST_RESET = 1'b0;
  localparam int ST_LEVEL_LSB = 0;
  localparam int ST_SERIAL_BIT = 8;
  localparam int ST_FULL_BIT = 9;
  localparam int ST_TEST_BIT = 10;

  // arctangent step in turn units scaled to Z_W bits
  function automatic logic signed [Z_W-1:0] atan_step(input int i);
    real a;
    a = $atan(2.0 ** (-i)) / TWO_PI * (2.0 ** Z_W);
    return Z_W'($rtoi(a + 0.5));
  endfunction : atan_step

endpackage : nco_out_pkg

// ==== nco_sine_cosine_output.sv ====
`timescale 1ns/1ps
`default_nettype none

module fifo_buf #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_CNT = (PTR_W + 1)'(DEPTH);

  logic [W-1:0] mem_r [0:DEPTH-1];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [PTR_W:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != FULL_CNT);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign level = cnt_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  // occupancy
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (push && !pop) begin
      cnt_r <= cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule : fifo_buf

module nco_sine_cosine_output #(
  parameter int FIFO_DEPTH_P = nco_out_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [nco_out_pkg::PHASE_W-1:0] phase_in,
  output logic phase_ready,
  input wire logic offset_binary_select_n,
  input wire logic parallel_serial_select,
  input wire logic phase_load_enable_n,
  output logic [nco_out_pkg::OUT_W-1:0] sine_out,
  output logic [nco_out_pkg::OUT_W-1:0] cosine_out,
  output logic word_start_strobe_n,
  input wire logic [nco_out_pkg::AV_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import nco_out_pkg::*;

  logic pipe_en;
  logic signed [XY_W-1:0] x_r [0:ITER];
  logic signed [XY_W-1:0] y_r [0:ITER];
  logic signed [Z_W-1:0] z_r [0:ITER];
  logic [QUAD_W-1:0] q_r [0:ITER];
  logic [ITER:0] v_r;
  logic [ADDR_W-1:0] addr;
  logic signed [OUT_W:0] cos_rnd;
  logic signed [OUT_W:0] sin_rnd;
  logic signed [OUT_W-1:0] cos_q;
  logic signed [OUT_W-1:0] sin_q;
  logic [FIFO_W-1:0] pair_r;
  logic pair_v_r;
  logic [FIFO_W-1:0] fifo_out;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic fifo_in_ready;
  logic [$clog2(FIFO_DEPTH_P):0] fifo_level;
  logic serial_mode;
  logic test_mode;
  logic load_now;
  logic [OUT_W-1:0] sin_fmt;
  logic [OUT_W-1:0] cos_fmt;
  logic [OUT_W-1:0] ms_sin_r;
  logic [OUT_W-1:0] ms_cos_r;
  logic [OUT_W-1:0] ls_sin_r;
  logic [OUT_W-1:0] ls_cos_r;
  logic cfg_test_r;
  logic resp_r;
  logic [31:0] status;

  // round guard bits away and clamp symmetric about zero
  function automatic logic signed [OUT_W:0] shrink(input logic signed [XY_W-1:0] v);
    logic signed [XY_W-1:0] t;
    t = (v + XY_W'(1 <<< (GUARD - 1))) >>> GUARD;
    if (t > XY_W'(OUT_POS_MAX)) begin
      return OUT_POS_MAX;
    end else if (t < XY_W'(OUT_NEG_MAX)) begin
      return OUT_NEG_MAX;
    end
    return t[OUT_W:0];
  endfunction : shrink

  // offset binary flips the top bit
  function automatic logic [OUT_W-1:0] fmt(input logic [OUT_W-1:0] w, input logic ob_n);
    return {w[OUT_W-1] ^ ~ob_n, w[OUT_W-2:0]};
  endfunction : fmt

  assign serial_mode = !parallel_serial_select;
  assign test_mode = parallel_serial_select && cfg_test_r;
  // whole lookup pipeline stalls while the buffer is full, so no pair is dropped
  assign pipe_en = fifo_in_ready;
  assign phase_ready = pipe_en;
  assign addr = phase_in[PHASE_W-1:ADDR_LSB];

  // quadrant split and first stage load
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      x_r[0] <= '0;
      y_r[0] <= '0;
      z_r[0] <= '0;
      q_r[0] <= '0;
      v_r[0] <= 1'b0;
    end else if (pipe_en) begin
      x_r[0] <= X_INIT;
      y_r[0] <= '0;
      z_r[0] <= {2'b00, addr[RESID_W-1:0], {GUARD{1'b0}}};
      q_r[0] <= addr[ADDR_W-1 -: QUAD_W];
      v_r[0] <= 1'b1;
    end
  end

  // rotation stages, residual angle below a quarter turn
  for (genvar i = 0; i < ITER; i++) begin : g_rot
    localparam logic signed [Z_W-1:0] ANG = atan_step(i);
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        x_r[i+1] <= '0;
        y_r[i+1] <= '0;
        z_r[i+1] <= '0;
        q_r[i+1] <= '0;
        v_r[i+1] <= 1'b0;
      end else if (pipe_en) begin
        if (z_r[i][Z_W-1]) begin
          x_r[i+1] <= x_r[i] + (y_r[i] >>> i);
          y_r[i+1] <= y_r[i] - (x_r[i] >>> i);
          z_r[i+1] <= z_r[i] + ANG;
        end else begin
          x_r[i+1] <= x_r[i] - (y_r[i] >>> i);
          y_r[i+1] <= y_r[i] + (x_r[i] >>> i);
          z_r[i+1] <= z_r[i] - ANG;
        end
        q_r[i+1] <= q_r[i];
        v_r[i+1] <= v_r[i];
      end
    end
  end

  assign cos_rnd = shrink(x_r[ITER]);
  assign sin_rnd = shrink(y_r[ITER]);
  assign cos_q = cos_rnd[OUT_W-1:0];
  assign sin_q = sin_rnd[OUT_W-1:0];

  // quadrant restore, symmetric clamp keeps 8000H out
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pair_r <= '0;
      pair_v_r <= 1'b0;
    end else if (pipe_en) begin
      pair_v_r <= v_r[ITER];
      unique case (q_r[ITER])
        2'h0: pair_r <= {sin_q, cos_q};
        2'h1: pair_r <= {cos_q, -sin_q};
        2'h2: pair_r <= {-sin_q, -cos_q};
        2'h3: pair_r <= {-cos_q, sin_q};
      endcase
    end
  end

  fifo_buf #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH_P)
  ) fifo_buf_inst (
    .clk(clk),
    .rst_b(rst_b),
    .in_data(pair_r),
    .in_valid(pair_v_r),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .level(fifo_level)
  );

  // a load with an empty buffer is ignored and shifting goes on
  assign load_now = serial_mode && !phase_load_enable_n;
  assign fifo_out_ready = serial_mode ? !phase_load_enable_n : 1'b1;
  assign sin_fmt = fmt(fifo_out[FIFO_W-1:OUT_W], offset_binary_select_n);
  assign cos_fmt = fmt(fifo_out[OUT_W-1:0], offset_binary_select_n);

  // serial shift registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ms_sin_r <= '0;
      ms_cos_r <= '0;
      ls_sin_r <= '0;
      ls_cos_r <= '0;
    end else if (load_now && fifo_out_valid) begin
      ms_sin_r <= sin_fmt;
      ms_cos_r <= cos_fmt;
      ls_sin_r <= sin_fmt;
      ls_cos_r <= cos_fmt;
    end else if (serial_mode) begin
      ms_sin_r <= {ms_sin_r[OUT_W-2:0], 1'b0};
      ms_cos_r <= {ms_cos_r[OUT_W-2:0], 1'b0};
      ls_sin_r <= {ls_sin_r[OUT_W-1], ls_sin_r[OUT_W-1:1]};
      ls_cos_r <= {ls_cos_r[OUT_W-1], ls_cos_r[OUT_W-1:1]};
    end
  end

  // output pins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sine_out <= '0;
      cosine_out <= '0;
    end else if (test_mode) begin
      sine_out <= phase_in[PHASE_W-1 -: OUT_W];
      cosine_out <= {phase_in[OUT_W-1:TEST_COS_LSB], {TEST_COS_LSB{1'b0}}};
    end else if (serial_mode) begin
      if (load_now && fifo_out_valid) begin
        sine_out <= {sin_fmt[OUT_W-1], {(OUT_W-2){1'b0}}, sin_fmt[0]};
        cosine_out <= {cos_fmt[OUT_W-1], {(OUT_W-2){1'b0}}, cos_fmt[0]};
      end else begin
        sine_out <= {ms_sin_r[OUT_W-2], {(OUT_W-2){1'b0}}, ls_sin_r[1]};
        cosine_out <= {ms_cos_r[OUT_W-2], {(OUT_W-2){1'b0}}, ls_cos_r[1]};
      end
    end else if (fifo_out_valid) begin
      sine_out <= sin_fmt;
      cosine_out <= cos_fmt;
    end
  end

  // word start strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      word_start_strobe_n <= 1'b1;
    end else begin
      word_start_strobe_n <= !(load_now && fifo_out_valid && !test_mode);
    end
  end

  // register slave, one wait state per access
  assign avs_waitrequest = (avs_read || avs_write) && !resp_r;

  // marks the second cycle of an access, the completion edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      resp_r <= 1'b0;
    end else begin
      resp_r <= (avs_read || avs_write) && !resp_r;
    end
  end

  // config write lands on the completion edge, once the wait state is over
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_test_r <= CFG_TEST_RESET;
    end else if (avs_write && resp_r && avs_address == CFG_OFF) begin
      cfg_test_r <= avs_writedata[CFG_TEST_BIT];
    end
  end

  // status word: buffer level, serial mode, buffer full, test active
  always_comb begin
    status = '0;
    status[ST_LEVEL_LSB +: $clog2(FIFO_DEPTH_P) + 1] = fifo_level;
    status[ST_SERIAL_BIT] = serial_mode;
    status[ST_FULL_BIT] = !fifo_in_ready;
    status[ST_TEST_BIT] = test_mode;
  end

  // read data loaded on the first edge and held through the completion edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      avs_readdata <= '0;
    end else if (avs_read && !resp_r) begin
      unique case (avs_address)
        CFG_OFF: avs_readdata <= {31'h0, cfg_test_r};
        STATUS_OFF: avs_readdata <= status;
        default: avs_readdata <= 32'h0;
      endcase
    end
  end
endmodule : nco_sine_cosine_output

`default_nettype wire

// ==== nco_out_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module nco_out_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic phase_ready,
  input wire logic offset_binary_select_n,
  input wire logic parallel_serial_select,
  input wire logic phase_load_enable_n,
  input wire logic [nco_out_pkg::OUT_W-1:0] sine_out,
  input wire logic [nco_out_pkg::OUT_W-1:0] cosine_out,
  input wire logic word_start_strobe_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  import nco_out_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // strobe, then 14 cycles of serial shifting with no new load
  sequence word_run;
    !word_start_strobe_n && phase_load_enable_n && !parallel_serial_select
    ##1 (phase_load_enable_n && !parallel_serial_select) [*8]
    ##1 (phase_load_enable_n && !parallel_serial_select) [*6];
  endsequence
  a_strobe_cause: assert property (
    !word_start_strobe_n |-> $past(!phase_load_enable_n && !parallel_serial_select))
    else $error("strobe without serial load");
  a_full_load: assert property (
    !phase_ready && !phase_load_enable_n && !parallel_serial_select |=> !word_start_strobe_n)
    else $error("load with full buffer gave no strobe");
  a_lsb_end: assert property (
    word_run |=> sine_out[0] == $past(sine_out[15], 15)
      && cosine_out[0] == $past(cosine_out[15], 15))
    else $error("bottom pin last bit differs from top pin first bit");
  a_msb_zero: assert property (
    word_run ##1 phase_load_enable_n |=> sine_out[15] == 1'b0 && cosine_out[15] == 1'b0)
    else $error("top pin not zero after word");
  a_sign_repeat: assert property (
    word_run ##1 phase_load_enable_n |=> $stable(sine_out[0]) && $stable(cosine_out[0]))
    else $error("bottom pin sign not repeated");
  a_mid_zero: assert property (
    !parallel_serial_select && $past(!parallel_serial_select)
      |-> sine_out[14:1] == 14'h0 && cosine_out[14:1] == 14'h0)
    else $error("unused serial pins not zero");
  a_no_neg_full: assert property (
    parallel_serial_select && $past(parallel_serial_select) && $past(offset_binary_select_n)
      && $past(offset_binary_select_n, 2) |-> sine_out != 16'h8000 && cosine_out != 16'h8000)
    else $error("most negative code seen");
  a_par_no_strobe: assert property (
    parallel_serial_select && $past(parallel_serial_select) |-> word_start_strobe_n)
    else $error("strobe in parallel mode");
  a_wait_once: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus wait state count wrong");
endmodule : nco_out_asserts
bind nco_sine_cosine_output nco_out_asserts nco_out_asserts_inst (
  .clk, .rst_b, .phase_ready, .offset_binary_select_n, .parallel_serial_select,
  .phase_load_enable_n, .sine_out, .cosine_out, .word_start_strobe_n,
  .avs_read, .avs_write, .avs_waitrequest);
`default_nettype wire

// ==== dac_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dac_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic slow,
  input wire logic top_sin,
  input wire logic top_cos,
  input wire logic word_start_strobe_n,
  output logic phase_load_enable_n,
  output logic [15:0] sin_w,
  output logic [15:0] cos_w,
  output logic [7:0] cnt
);
  logic [4:0] ph_r;
  logic [4:0] k_r;
  logic [15:0] s_r;
  logic [15:0] c_r;
  // load one clock, then 15 or 31 idle clocks
  always_ff @(posedge clk) begin
    if (!rst_b || !run) begin
      ph_r <= 5'h00;
      phase_load_enable_n <= 1'b1;
    end else begin
      ph_r <= (ph_r == (slow ? 5'h1F : 5'h0F)) ? 5'h00 : ph_r + 5'h01;
      phase_load_enable_n <= (ph_r != 5'h00);
    end
  end
  // gathers the msb-first stream into words
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      k_r <= 5'h00;
      cnt <= 8'h00;
    end else if (!word_start_strobe_n) begin
      k_r <= 5'h01;
      s_r <= {15'h0, top_sin};
      c_r <= {15'h0, top_cos};
    end else if (k_r != 5'h00) begin
      s_r <= {s_r[14:0], top_sin};
      c_r <= {c_r[14:0], top_cos};
      k_r <= (k_r == 5'h0F) ? 5'h00 : k_r + 5'h01;
      if (k_r == 5'h0F) begin
        sin_w <= {s_r[14:0], top_sin};
        cos_w <= {c_r[14:0], top_cos};
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule : dac_model
`default_nettype wire

// ==== test_nco_sine_cosine_output.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_nco_sine_cosine_output;
  import nco_out_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] phase_in = 32'h0;
  logic offset_binary_select_n = 1'b1;
  logic parallel_serial_select = 1'b1;
  logic phase_load_enable_n, phase_ready, word_start_strobe_n, avs_waitrequest;
  logic [15:0] sine_out, cosine_out, sin_w, cos_w;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic run = 1'b0;
  logic slow = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [7:0] cnt;
  logic [31:0] ph [5] = '{32'h0, 32'h4000_0000, 32'h8000_0000, 32'hC000_0FFF, 32'h2000_0000};
  logic [31:0] ex [5] = '{32'h0000_7FFF, 32'h7FFF_0000, 32'h0000_8001, 32'h8001_0000,
    32'h5A82_5A82};
  int errors = 0;
  int checks = 0;
  always #20 clk = ~clk;
  nco_sine_cosine_output nco_sine_cosine_output_inst (.clk, .rst_b, .phase_in, .phase_ready,
    .offset_binary_select_n, .parallel_serial_select, .phase_load_enable_n, .sine_out,
    .cosine_out, .word_start_strobe_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest);
  dac_model dac_model_inst (.clk, .rst_b, .run, .slow, .top_sin(sine_out[15]),
    .top_cos(cosine_out[15]), .word_start_strobe_n, .phase_load_enable_n, .sin_w, .cos_w, .cnt);
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input int tol);
    logic signed [15:0] d;
    d = s[15:0] - e[15:0];
    checks++;
    if (((s[31:16] === e[31:16]) && d <= tol && d >= -tol) !== 1'b1) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) errors++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic test_done;
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial begin
    #400000;
    errors++;
    test_done;
  end
  initial begin
    cyc(10);
    rst_b <= 1'b1;
    bus(1'b1, 4'h8, 32'hFFFF_FFFF);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0, 0);
    bus(1'b0, CFG_OFF, 32'h0);
    chk(q, 32'h0, 0);
    for (int f = 0; f < 2; f++) begin
      offset_binary_select_n <= (f == 0);
      for (int i = 0; i < 5; i++) begin
        phase_in <= ph[i];
        cyc(30);
        chk({16'h0, sine_out}, {16'h0, ex[i][31:16] ^ (f ? 16'h8000 : 16'h0)}, 2);
        chk({16'h0, cosine_out}, {16'h0, ex[i][15:0] ^ (f ? 16'h8000 : 16'h0)}, 2);
      end
    end
    offset_binary_select_n <= 1'b1;
    phase_in <= 32'h1234_5678;
    bus(1'b1, CFG_OFF, 32'h1);
    cyc(2);
    chk({sine_out, cosine_out}, 32'h1234_5670, 0);
    bus(1'b0, STATUS_OFF, 32'h0);
    chk({31'h0, q[10]}, 32'h1, 0);
    bus(1'b1, CFG_OFF, 32'h0);
    phase_in <= 32'h0;
    cyc(30);
    phase_in <= 32'h4000_0000;
    cyc(22);
    chk({16'h0, sine_out}, 32'h0, 2);
    cyc(1);
    chk({16'h0, sine_out}, 32'h7FFF, 2);
    parallel_serial_select <= 1'b0;
    for (int n = 0; n < 100 && phase_ready !== 1'b0; n++) cyc(1);
    bus(1'b0, STATUS_OFF, 32'h0);
    chk(q, 32'h0000_0310, 0);
    run <= 1'b1;
    for (int n = 0; n < 200 && cnt < 8'd3; n++) cyc(1);
    chk({24'h0, cnt}, 32'h3, 0);
    chk({16'h0, sin_w}, 32'h7FFF, 2);
    chk({16'h0, cos_w}, 32'h0, 2);
    slow <= 1'b1;
    offset_binary_select_n <= 1'b0;
    for (int n = 0; n < 400 && cnt < 8'd6; n++) cyc(1);
    chk({24'h0, cnt}, 32'h6, 0);
    chk({16'h0, sin_w}, 32'hFFFF, 2);
    chk({16'h0, cos_w}, 32'h8000, 2);
    run <= 1'b0;
    parallel_serial_select <= 1'b1;
    offset_binary_select_n <= 1'b1;
    cyc(40);
    bus(1'b0, STATUS_OFF, 32'h0);
    chk({30'h0, q[9:8]}, 32'h0, 0);
    test_done;
  end
endmodule : test_nco_sine_cosine_output
`default_nettype wire
